// *** sim/safety_sensor_serial_diag_bench.sv ***
// bench for the safety sensor core driven by the gateway model
// assumes the hand-over latencies, so ten cycles always settle a change
`timescale 1ns/10ps
module safety_sensor_serial_diag_bench;
  import ssd_pkg::*;
  logic clk_sys, resetn, strap, ia, ib, act, lim, fbc, ackb, fint, comm, nvl;
  logic nv_disc_write, nv_disc_value, xs, oa, ob, led;
  logic [3:0] fw;
  logic [7:0] cmd, cb, rpt, det;
  int miscompares, total_checks, seed, nvn;
  ssd_core u_ssd_core (.clk_sys, .resetn, .edge_triggered_restart(strap),
    .disc_monitor_en(1'b1), .safety_input_a(ia), .safety_input_b(ib),
    .actuator_present(act), .actuator_in_limit(lim), .actuator_bad(1'b0),
    .feedback_closed(fbc), .ack_button(ackb), .fault_out_a(fw[0]), .fault_out_b(fw[1]),
    .fault_cross(fw[2]), .fault_temp(fw[3]), .fault_internal(fint), .comm_fault(comm),
    .nv_disc_latched(nvl), .nv_disc_write, .nv_disc_value, .xfer_strobe(xs),
    .command_byte(cb), .state_report_byte(rpt), .fault_detail_byte(det),
    .safety_output_a(oa), .safety_output_b(ob), .actuator_led_fast(led));
  ssd_gateway_model u_ssd_gateway_model (.clk_sys, .resetn, .cmd, .xfer_strobe(xs),
    .command_byte(cb));
  // ====
  // clock, store, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (nv_disc_write) begin
      nvl <= nv_disc_value;
      nvn <= nvn + 1;
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    final_report;
  end
  // ====
  // helpers
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // expected report from pin state; m is error, warning, outputs on
  function automatic logic [7:0] xr(input logic [2:0] m);
    return {m[2], m[1] | m[2], lim & act & ~m[2], ia & ib, 2'b00, act, m[0]};
  endfunction
  task automatic rst(input logic s, input logic n);
    resetn = 1'b0;
    strap = s;
    nvl = n;
    st(5);
    resetn = 1'b1;
    st(10);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ====
  // scenarios
  initial begin
    {resetn, strap, ia, ib, act, lim, fbc, ackb, fint, comm, nvl, fw, cmd} = '0;
    {miscompares, total_checks, nvn} = '0;
    seed = 69;
    ia = 1'b1;
    ib = 1'b1;
    rst(1'b0, 1'b0);
    act = 1'b1;
    st(10);
    chk(rpt & 8'hF7, xr(3'b000));
    fbc = 1'b1;
    st(10);
    chk({7'h00, oa}, 8'h01);
    lim = 1'b1;
    st(10);
    chk(rpt & 8'hF7, xr(3'b001));
    lim = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fw = 4'h1 << i;
      st(10);
      chk(det, 8'h01 << i);
      chk(rpt & 8'hF7, xr(3'b011));
      fw = 4'h0;
      st(10);
      chk(rpt & 8'hF7, xr(3'b001));
    end
    comm = 1'b1;
    ia = 1'b0;
    st(10);
    chk(det, 8'h40);
    chk({7'h00, oa}, 8'h01);
    ia = 1'b1;
    comm = 1'b0;
    fint = 1'b1;
    st(10);
    chk(det, 8'h20);
    chk(rpt & 8'hF7, xr(3'b100));
    fint = 1'b0;
    cmd = 8'h80 | 8'($random(seed) & 32'h3F);
    st(10);
    chk(rpt & 8'hF7, xr(3'b100));
    cmd = 8'($random(seed) & 32'h3F);
    st(10);
    chk(rpt & 8'hF6, xr(3'b000));
    fbc = 1'b0;
    rst(1'b1, 1'b1);
    chk(det, 8'h40);
    fbc = 1'b1;
    st(10);
    fbc = 1'b0;
    st(10);
    chk(rpt & 8'hF7, xr(3'b100));
    ackb = 1'b1;
    st(10);
    ackb = 1'b0;
    st(10);
    chk({nvl, nvn[6:0]}, 8'h01);
    chk(rpt & 8'hF6, xr(3'b000));
    fbc = 1'b1;
    st(10);
    chk({7'h00, oa}, 8'h00);
    fbc = 1'b0;
    st(10);
    chk({7'h00, oa}, 8'h01);
    final_report;
  end
endmodule

// *** sim/ssd_core_props.sv ***
// checker for the safety sensor core, port relations only
// assumes it is bound to every ssd_core instance
`timescale 1ns/10ps
module ssd_core_props
  import ssd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // watched pins
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic actuator_present,
  input wire logic comm_fault,
  input wire logic nv_disc_write,
  input wire logic [7:0] state_report_byte,
  input wire logic [7:0] fault_detail_byte,
  input wire logic safety_output_a,
  input wire logic safety_output_b,
  input wire logic actuator_led_fast
);
  // ====
  // properties
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  outs_paired_a: assert property (safety_output_a == safety_output_b)
    else $error("outputs differ");
  rise_cause_a: assert property (
    $rose(safety_output_a) |-> $past(actuator_present, 3))
    else $error("enable without actuator");
  err_off_a: assert property ($rose(state_report_byte[RPT_ERROR]) |-> !safety_output_a)
    else $error("error with outputs on");
  reset_quiet_a: assert property (
    $rose(resetn) |-> !safety_output_a && state_report_byte == 8'h00)
    else $error("outputs not quiet after reset");
  cause_shown_a: assert property (
    (state_report_byte[RPT_WARN] || state_report_byte[RPT_ERROR]) |-> fault_detail_byte != 8'h00)
    else $error("fault without cause");
  nv_pulse_a: assert property (nv_disc_write |=> !nv_disc_write)
    else $error("store write too long");
  comm_hold_a: assert property (comm_fault [*6] |-> $stable(safety_output_a))
    else $error("outputs moved on comm loss");
  led_waiting_a: assert property (actuator_led_fast |-> !safety_output_a)
    else $error("fast flash with outputs on");
  live_bit_a: assert property (
    (safety_input_a && safety_input_b) [*8] |-> state_report_byte[RPT_INPUTS_LIVE])
    else $error("inputs live bit missing");
endmodule

bind ssd_core ssd_core_props u_ssd_core_props (.clk_sys, .resetn, .safety_input_a,
  .safety_input_b, .actuator_present, .comm_fault, .nv_disc_write, .state_report_byte,
  .fault_detail_byte, .safety_output_a, .safety_output_b, .actuator_led_fast);

// *** sim/ssd_gateway_model.sv ***
// gateway model: one exchange every four cycles carrying the bench command
// assumes the bench holds cmd steady between exchanges
`timescale 1ns/10ps
module ssd_gateway_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // command wanted
  input wire logic [7:0] cmd,
  // exchange
  output logic xfer_strobe,
  output logic [7:0] command_byte
);
  logic [1:0] cnt;
  // ====
  // pacing
  initial begin
    xfer_strobe = 1'b0;
    command_byte = 8'h00;
    cnt = 2'h0;
    forever begin
      @(posedge clk_sys);
      #2;
      cnt = resetn ? cnt + 2'h1 : 2'h0;
      xfer_strobe = (cnt == 2'h3);
      // outside an exchange the byte is not valid, so show its inverse
      command_byte = xfer_strobe ? cmd : ~cmd;
    end
  end
endmodule

// *** src/ssd_core.sv ***
// status, diagnostic and restart core of a non-contact safety sensor
// assumes pins arrive asynchronous, the serial channel framing lives outside,
// and a non-volatile store outside holds the discrepancy latch bit
`timescale 1ns/10ps
module ssd_core
  import ssd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // strap: 1 selects edge-triggered restart, 0 close-triggered
  input wire logic edge_triggered_restart,
  input wire logic disc_monitor_en,
  // sensor pins (asynchronous)
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic actuator_present,
  input wire logic actuator_in_limit,
  input wire logic actuator_bad,
  input wire logic feedback_closed,
  input wire logic ack_button,
  // fault sources (asynchronous)
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic fault_cross,
  input wire logic fault_temp,
  input wire logic fault_internal,
  input wire logic comm_fault,
  // non-volatile discrepancy latch
  input wire logic nv_disc_latched,
  output logic nv_disc_write,
  output logic nv_disc_value,
  // serial exchange: one-cycle strobe with command byte
  input wire logic xfer_strobe,
  input wire logic [7:0] command_byte,
  output logic [7:0] state_report_byte,
  output logic [7:0] fault_detail_byte,
  // outputs
  output logic safety_output_a,
  output logic safety_output_b,
  output logic actuator_led_fast
);
  localparam int NS = 13;

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    ssd_state_t st;
    logic strap_taken;
    logic edge_mode;
    logic nv_loaded;
    logic disc_err;
    logic int_err;
    logic warn_err;
    logic cmd7;
    logic ack_prev;
    logic fb_prev;
    logic comm_prev;
    logic [31:0] flash_cnt;
    logic flash;
    logic [7:0] rpt;
    logic [7:0] det;
    logic nv_we;
    logic nv_val;
  } ssd_regs_t;

  ssd_regs_t q_r;
  ssd_regs_t q_nxt;
  logic [NS-1:0] pin_raw;
  logic disc_run;
  logic disc_exp;
  logic warn_run;
  logic warn_exp;
  logic in_a;
  logic in_b;
  logic act;
  logic lim;
  logic badact;
  logic fb;
  logic ackb;
  logic f_a;
  logic f_b;
  logic f_x;
  logic f_t;
  logic f_i;
  logic comm;
  logic warn_any;
  logic out_on;

  assign pin_raw = {comm_fault, fault_internal, fault_temp, fault_cross, fault_out_b,
                    fault_out_a, ack_button, feedback_closed, actuator_bad,
                    actuator_in_limit, actuator_present, safety_input_b, safety_input_a};
  assign {comm, f_i, f_t, f_x, f_b, f_a, ackb, fb, badact, lim, act, in_b, in_a} = q_r.s2;

  // ============================================================
  // timers
  assign disc_run = disc_monitor_en && (in_a != in_b);
  assign warn_any = f_a || f_b || f_x || f_t;
  assign warn_run = warn_any && (q_r.st == SSD_ENABLED);
  assign out_on = (q_r.st == SSD_ENABLED);

  ssd_timer #(.LIMIT(DISC_CYCLES)) u_disc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(disc_run),
    .expired(disc_exp)
  );

  ssd_timer #(.LIMIT(WARN_CYCLES)) u_warn (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(warn_run),
    .expired(warn_exp)
  );

  // ============================================================
  // next state
  always_comb begin
    logic ack_fall;
    logic btn_fall;
    logic cmd_ack;
    logic cmd7_fall;
    logic guard_open;
    logic restart;
    logic hold;
    logic [7:0] rpt_v;
    logic [7:0] det_v;
    ack_fall = 1'b0;
    btn_fall = 1'b0;
    cmd_ack = 1'b0;
    cmd7_fall = 1'b0;
    guard_open = 1'b0;
    restart = 1'b0;
    hold = 1'b0;
    rpt_v = BYTE_RST;
    det_v = BYTE_RST;
    q_nxt = q_r;
    q_nxt.s1 = pin_raw;
    q_nxt.s2 = q_r.s1;
    q_nxt.ack_prev = ackb;
    q_nxt.fb_prev = fb;
    q_nxt.comm_prev = comm;
    q_nxt.nv_we = 1'b0;

    // strap is caught once after release of reset
    if (!q_r.strap_taken) begin
      q_nxt.strap_taken = 1'b1;
      q_nxt.edge_mode = edge_triggered_restart;
    end
    if (!q_r.nv_loaded) begin
      q_nxt.nv_loaded = 1'b1;
      q_nxt.disc_err = nv_disc_latched;
    end

    ack_fall = q_r.ack_prev && !ackb;
    btn_fall = q_r.fb_prev && !fb;
    guard_open = !act;
    if (xfer_strobe) begin
      cmd_ack = command_byte[CMD_DISC_ACK];
      cmd7_fall = q_r.cmd7 && !command_byte[CMD_ERR_RESET];
      q_nxt.cmd7 = command_byte[CMD_ERR_RESET];
    end

    // discrepancy latch: new error wins over an acknowledge in the same cycle
    if (disc_exp) begin
      q_nxt.disc_err = 1'b1;
      q_nxt.nv_we = 1'b1;
      q_nxt.nv_val = 1'b1;
    end else if (q_r.disc_err && q_r.nv_loaded && (ack_fall || cmd_ack)) begin
      q_nxt.disc_err = 1'b0;
      q_nxt.nv_we = 1'b1;
      q_nxt.nv_val = 1'b0;
    end

    // internal error: set while cause present, cleared by bit7 fall or guard open
    if (f_i || badact) begin
      q_nxt.int_err = 1'b1;
    end else if (q_r.int_err && (cmd7_fall || guard_open)) begin
      q_nxt.int_err = 1'b0;
    end

    if (warn_exp) begin
      q_nxt.warn_err = 1'b1;
    end else if (!warn_any) begin
      q_nxt.warn_err = 1'b0;
    end

    // comm loss freezes the output state against restart and drop-out; a fault still drops it
    hold = comm;

    restart = q_r.edge_mode ? btn_fall : fb;
    case (q_r.st)
      SSD_WAIT_RESTART: begin
        if (q_nxt.int_err || q_r.warn_err || q_r.disc_err) begin
          q_nxt.st = SSD_FAULT;
        end else if (!hold && restart && act && in_a && in_b && q_r.nv_loaded) begin
          q_nxt.st = SSD_ENABLED;
        end
      end
      SSD_ENABLED: begin
        if (disc_exp || q_nxt.int_err || warn_exp) begin
          q_nxt.st = SSD_FAULT;
        // in the edge variant the button is released to enable, so open feedback is normal
        end else if (!hold && (!act || !in_a || !in_b || (!fb && !q_r.edge_mode))) begin
          q_nxt.st = SSD_WAIT_RESTART;
        end
      end
      SSD_FAULT: begin
        // no re-enable until every latched cause has gone
        if (!q_nxt.disc_err && !q_nxt.int_err && !q_nxt.warn_err) begin
          q_nxt.st = SSD_WAIT_RESTART;
        end
      end
      default: q_nxt.st = SSD_WAIT_RESTART;
    endcase

    // fast flash while actuated and waiting for restart
    if (q_r.flash_cnt >= 32'(FLASH_HALF_CYCLES - 1)) begin
      q_nxt.flash_cnt = CNT_RST;
      q_nxt.flash = !q_r.flash;
    end else begin
      q_nxt.flash_cnt = q_r.flash_cnt + 32'h0000_0001;
    end

    // report bytes rebuilt every cycle, so every exchange sees fresh state
    rpt_v[RPT_OUT_ON] = out_on;
    rpt_v[RPT_ACTUATOR] = act;
    rpt_v[RPT_FB_OPEN] = (q_r.st == SSD_WAIT_RESTART) && act;
    rpt_v[RPT_INPUTS_LIVE] = in_a && in_b;
    rpt_v[RPT_LIMIT] = act && lim;
    rpt_v[RPT_WARN] = warn_any || f_i || comm || q_r.st == SSD_FAULT;
    rpt_v[RPT_ERROR] = (q_r.st == SSD_FAULT);
    det_v[DET_OUT_A] = f_a;
    det_v[DET_OUT_B] = f_b;
    det_v[DET_CROSS] = f_x;
    det_v[DET_TEMP] = f_t;
    det_v[DET_INTERNAL] = f_i || q_r.int_err;
    if (q_r.st == SSD_FAULT) begin
      det_v[DET_BAD_ACT] = badact;
      det_v[DET_COMM_DISC] = q_r.disc_err;
    end else begin
      det_v[DET_COMM_DISC] = comm;
    end
    q_nxt.rpt = rpt_v;
    q_nxt.det = det_v;
  end

  // ============================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      q_r <= '0;
      q_r.st <= SSD_WAIT_RESTART;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ============================================================
  // outputs, straight from flip-flops
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
      actuator_led_fast <= 1'b0;
      state_report_byte <= BYTE_RST;
      fault_detail_byte <= BYTE_RST;
      nv_disc_write <= 1'b0;
      nv_disc_value <= 1'b0;
    end else begin
      safety_output_a <= (q_nxt.st == SSD_ENABLED);
      safety_output_b <= (q_nxt.st == SSD_ENABLED);
      actuator_led_fast <= (q_r.st == SSD_WAIT_RESTART) && act && q_r.flash;
      state_report_byte <= q_r.rpt;
      fault_detail_byte <= q_r.det;
      nv_disc_write <= q_r.nv_we;
      nv_disc_value <= q_r.nv_val;
    end
  end
endmodule

// *** src/ssd_pkg.sv ***
// package for the safety sensor status, diagnostic and restart block
// assumes a single 40 MHz system clock; all timing is counted in its cycles
package ssd_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // times in their own units, as printed
  localparam int unsigned DISC_TIME_MS = 500;
  localparam int unsigned WARN_TIME_MIN = 30;
  localparam int unsigned FLASH_FAST_HZ = 5;
  // derived cycle counts (shorter times round down)
  localparam longint unsigned DISC_CYCLES = longint'(CLK_HZ) * DISC_TIME_MS / 1000;
  localparam longint unsigned WARN_CYCLES = longint'(CLK_HZ) * 60 * WARN_TIME_MIN;
  localparam int unsigned FLASH_HALF_CYCLES = CLK_HZ / (2 * FLASH_FAST_HZ);

  // state report byte fields
  localparam int unsigned RPT_OUT_ON = 0;
  localparam int unsigned RPT_ACTUATOR = 1;
  localparam int unsigned RPT_FB_OPEN = 3;
  localparam int unsigned RPT_INPUTS_LIVE = 4;
  localparam int unsigned RPT_LIMIT = 5;
  localparam int unsigned RPT_WARN = 6;
  localparam int unsigned RPT_ERROR = 7;
  // fault detail byte fields
  localparam int unsigned DET_OUT_A = 0;
  localparam int unsigned DET_OUT_B = 1;
  localparam int unsigned DET_CROSS = 2;
  localparam int unsigned DET_TEMP = 3;
  localparam int unsigned DET_BAD_ACT = 4;
  localparam int unsigned DET_INTERNAL = 5;
  localparam int unsigned DET_COMM_DISC = 6;
  // command byte fields
  localparam int unsigned CMD_ERR_RESET = 7;
  localparam int unsigned CMD_DISC_ACK = 6;

  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SSD_WAIT_RESTART,
    SSD_ENABLED,
    SSD_FAULT
  } ssd_state_t;
endpackage

// *** src/ssd_timer.sv ***
// saturating cycle timer, counts while run is high, clears otherwise
// assumes same clock domain as the caller
`timescale 1ns/10ps
module ssd_timer #(
  parameter longint unsigned LIMIT = 64'd10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control
  input wire logic run,
  output logic expired
);
  // 64 bits because the warning delay needs more than 32 bits of cycles
  logic [63:0] cnt_r;
  logic [63:0] cnt_nxt;
  localparam logic [63:0] LIM = 64'(LIMIT);

  always_comb begin
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = 64'h0000_0000_0000_0000;
    end else if (cnt_r != LIM) begin
      cnt_nxt = cnt_r + 64'h0000_0000_0000_0001;
    end
  end

  // expired is a single pulse on reaching the limit, not a level while saturated
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_r <= 64'h0000_0000_0000_0000;
      expired <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expired <= run && (cnt_r != LIM) && (cnt_nxt == LIM);
    end
  end
endmodule
